// *** logic/supervisor_watchdog_reset_hold.sv ***
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "supervisor_consts.svh"

// Behaviour
// - Power-fail flag low while sense input is below reference, high otherwise.
// - Reset output stays low while the regulator output is below threshold.
// - After any reset condition ends, reset stays low one full timeout.
// - Reset-period select high uses fixed timeout, else capacitor-set timeout.
// - Watchdog-period select high uses fixed timeout, else capacitor-set timeout.
// - Non-windowed: an edge needed each watchdog period, else a timed reset.
// - Watchdog counter clears on each accepted kick edge and during reset.
// - Windowed: kicks too early or too late force reset for timeout.
// - Windowed: counter idle during reset, counts only after release.
// - Window selects pick late/early ratio; when windowed, one code disables the watchdog.
// - Windowed: watchdog disabled when low select is high and high select low.
// - Keep-on low holds regulator one on after its enable drops.
// - Regulator turns off when keep-on released while enable is low.
// - Unconnected keep-on input reads as inactive high.
// - Early limit is normal timeout divided by ratio 8, 16 or 64.
// - Non-windowed: dedicated watchdog-off input low disables, high enables the watchdog.
module supervisor_watchdog_reset_hold
#(
   parameter int unsigned RST_FIXED_CYC = `RST_FIXED_CYC_DEF,
   parameter int unsigned WD_FIXED_CYC = `WD_FIXED_CYC_DEF,
   parameter bit WINDOWED = 1'b1
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire supervisor_pkg::apb_addr_t paddr,
   input wire supervisor_pkg::word_t pwdata,
   output supervisor_pkg::word_t prdata,
   output logic pready,
   output logic pslverr,
   // Analog comparator results
   input wire logic power_fail_sense,
   input wire logic supply_low,
   // Period straps
   input wire logic reset_period_select,
   input wire logic wdog_period_select,
   // Watchdog
   input wire logic wdog_kick_in,
   input wire logic window_sel_lo,
   input wire logic window_sel_hi,
   input wire logic wdog_off_n,
   // Regulator hold
   input wire logic regulator_one_on,
   input wire logic keep_on_n,
   input wire logic keep_on_driven,
   output logic supply_one_out,
   // Supervisor outputs
   output logic reset_out_n,
   output logic power_fail_flag_n,
   output logic irq
);
   import supervisor_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   rst_state_t state_r;
   rst_state_t state_nxt;
   word_t rst_cnt_r;
   word_t wd_cnt_r;
   word_t rst_adj_r;
   word_t wd_adj_r;
   word_t rst_len;
   word_t wd_len;
   word_t early_len;
   word_t prdata_r;
   logic [`EV_COUNT-1:0] int_stat_r;
   logic [`EV_COUNT-1:0] int_en_r;
   logic [`EV_COUNT-1:0] int_clr;
   logic [`EV_COUNT-1:0] events;
   logic [2:0] ratio_shift;
   logic kick_s1_r;
   logic kick_s2_r;
   logic kick_s3_r;
   logic kick_edge;
   logic wd_en;
   logic wd_run;
   logic wd_late;
   logic wd_early;
   logic wd_fault;
   logic keep_on_eff;
   logic pready_r;
   logic pslverr_r;
   logic reset_out_n_r;
   logic pf_flag_n_r;
   logic supply_one_out_r;
   logic irq_r;
   logic apb_access;
   logic apb_commit;
   logic addr_hit;

   // ----------------------------------------
   // Timeout selection
   // ----------------------------------------
   // Capacitor-set periods are modelled by software-loaded cycle counts
   always_comb
   begin
      rst_len = reset_period_select ? RST_FIXED_CYC : rst_adj_r;
      wd_len = wdog_period_select ? WD_FIXED_CYC : wd_adj_r;
   end

   always_comb
   begin
      case ({window_sel_hi, window_sel_lo})
         2'b00: ratio_shift = `SHIFT_RATIO_8;
         2'b10: ratio_shift = `SHIFT_RATIO_16;
         default: ratio_shift = `SHIFT_RATIO_64;
      endcase
      early_len = wd_len >> ratio_shift;
   end

   always_comb
   begin
      if (WINDOWED)
      begin
         wd_en = ~(window_sel_lo & ~window_sel_hi);
      end
      else
      begin
         wd_en = wdog_off_n;
      end
   end

   // ----------------------------------------
   // Kick synchroniser and edge detect
   // ----------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         kick_s1_r <= 1'b0;
         kick_s2_r <= 1'b0;
         kick_s3_r <= 1'b0;
      end
      else
      begin
         kick_s1_r <= wdog_kick_in;
         kick_s2_r <= kick_s1_r;
         kick_s3_r <= kick_s2_r;
      end
   end

   assign kick_edge = kick_s2_r ^ kick_s3_r;

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   always_comb
   begin
      wd_run = (state_r == ST_RUN) & wd_en;
      // Compared as count plus one so a zero period cannot wrap into a huge limit
      wd_late = (wd_cnt_r + 32'h0000_0001) >= wd_len;
      wd_early = WINDOWED & kick_edge & (wd_cnt_r < early_len);
      wd_fault = wd_run & ((wd_late & ~kick_edge) | wd_early);
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !wd_run || wd_fault)
      begin
         wd_cnt_r <= 32'h0000_0000;
      end
      else if (kick_edge)
      begin
         wd_cnt_r <= 32'h0000_0000;
      end
      else
      begin
         wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
      end
   end

   // ----------------------------------------
   // Reset generator
   // ----------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_HOLD:
         begin
            if (!supply_low)
            begin
               state_nxt = ST_STRETCH;
            end
         end
         ST_STRETCH:
         begin
            if (supply_low)
            begin
               state_nxt = ST_HOLD;
            end
            else if ((rst_cnt_r + 32'h0000_0001) >= rst_len)
            begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (supply_low)
            begin
               state_nxt = ST_HOLD;
            end
            else if (wd_fault)
            begin
               state_nxt = ST_STRETCH;
            end
         end
         default:
         begin
            state_nxt = ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         state_r <= ST_HOLD;
         reset_out_n_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         reset_out_n_r <= (state_nxt == ST_RUN);
      end
   end

   // Counter restarts on every entry so the stretch is always a full period
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || state_r != ST_STRETCH || state_nxt != ST_STRETCH)
      begin
         rst_cnt_r <= 32'h0000_0000;
      end
      else
      begin
         rst_cnt_r <= rst_cnt_r + 32'h0000_0001;
      end
   end

   // ----------------------------------------
   // Power-fail flag and regulator hold
   // ----------------------------------------
   assign keep_on_eff = keep_on_driven ? keep_on_n : 1'b1;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         pf_flag_n_r <= 1'b1;
         supply_one_out_r <= 1'b0;
      end
      else
      begin
         pf_flag_n_r <= ~power_fail_sense;
         // Hold only extends an output that was already on
         supply_one_out_r <= regulator_one_on | (supply_one_out_r & ~keep_on_eff);
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   always_comb
   begin
      events = '0;
      events[`EV_WD_FAULT_BIT] = wd_fault;
      events[`EV_POWER_FAIL_BIT] = pf_flag_n_r & power_fail_sense;
      events[`EV_SUPPLY_LOW_BIT] = supply_low & (state_r != ST_HOLD);
   end

   // Set wins over a clear landing in the same cycle
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         int_stat_r <= '0;
         irq_r <= 1'b0;
      end
      else
      begin
         int_stat_r <= (int_stat_r & ~int_clr) | events;
         irq_r <= |(((int_stat_r & ~int_clr) | events) & int_en_r);
      end
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   // One wait state: pready rises in the second access cycle
   assign apb_access = psel & penable & ~pready_r;
   assign apb_commit = psel & penable & pready_r;

   always_comb
   begin
      addr_hit = 1'b1;
      if (paddr == `OFS_STATUS)
      begin
         addr_hit = 1'b1;
      end
      else if (paddr == `OFS_RST_ADJ || paddr == `OFS_WD_ADJ)
      begin
         addr_hit = 1'b1;
      end
      else if (paddr == `OFS_INT_STAT || paddr == `OFS_INT_EN || paddr == `OFS_INT_CLR)
      begin
         addr_hit = 1'b1;
      end
      else
      begin
         addr_hit = 1'b0;
      end
   end

   assign int_clr = (apb_commit && pwrite && paddr == `OFS_INT_CLR) ?
                    pwdata[`EV_COUNT-1:0] : '0;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         pready_r <= apb_access;
         pslverr_r <= apb_access & ~addr_hit;
         prdata_r <= 32'h0000_0000;
         if (apb_access && !pwrite)
         begin
            if (paddr == `OFS_STATUS)
            begin
               prdata_r[`ST_RESET_N_BIT] <= reset_out_n_r;
               prdata_r[`ST_PF_FLAG_N_BIT] <= pf_flag_n_r;
               prdata_r[`ST_SUPPLY_ON_BIT] <= supply_one_out_r;
               prdata_r[`ST_WD_EN_BIT] <= wd_en;
               prdata_r[`ST_STRETCH_BIT] <= (state_r == ST_STRETCH);
            end
            else if (paddr == `OFS_RST_ADJ)
            begin
               prdata_r <= rst_adj_r;
            end
            else if (paddr == `OFS_WD_ADJ)
            begin
               prdata_r <= wd_adj_r;
            end
            else if (paddr == `OFS_INT_STAT)
            begin
               prdata_r[`EV_COUNT-1:0] <= int_stat_r;
            end
            else if (paddr == `OFS_INT_EN)
            begin
               prdata_r[`EV_COUNT-1:0] <= int_en_r;
            end
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         rst_adj_r <= `RST_ADJ_RST;
         wd_adj_r <= `WD_ADJ_RST;
         int_en_r <= `INT_EN_RST;
      end
      else if (apb_commit && pwrite)
      begin
         if (paddr == `OFS_RST_ADJ)
         begin
            rst_adj_r <= pwdata;
         end
         else if (paddr == `OFS_WD_ADJ)
         begin
            wd_adj_r <= pwdata;
         end
         else if (paddr == `OFS_INT_EN)
         begin
            int_en_r <= pwdata[`EV_COUNT-1:0];
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign reset_out_n = reset_out_n_r;
   assign power_fail_flag_n = pf_flag_n_r;
   assign supply_one_out = supply_one_out_r;
   assign irq = irq_r;

endmodule

// *** logic/supervisor_consts.svh ***
`ifndef SUPERVISOR_CONSTS_SVH
`define SUPERVISOR_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 40000000
`define RST_FIXED_MS 200
`define WD_FIXED_MS 400
`define RST_FIXED_CYC_DEF (`RST_FIXED_MS * (`CLK_HZ / 1000))
`define WD_FIXED_CYC_DEF (`WD_FIXED_MS * (`CLK_HZ / 1000))

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_STATUS 12'h000
`define OFS_RST_ADJ 12'h004
`define OFS_WD_ADJ 12'h008
`define OFS_INT_STAT 12'h00C
`define OFS_INT_EN 12'h010
`define OFS_INT_CLR 12'h014

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ADJ_RST 32'h0000_1000
`define WD_ADJ_RST 32'h0000_2000
`define INT_EN_RST 3'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ST_RESET_N_BIT 0
`define ST_PF_FLAG_N_BIT 1
`define ST_SUPPLY_ON_BIT 2
`define ST_WD_EN_BIT 3
`define ST_STRETCH_BIT 4
`define EV_WD_FAULT_BIT 0
`define EV_POWER_FAIL_BIT 1
`define EV_SUPPLY_LOW_BIT 2
`define EV_COUNT 3

// ----------------------------------------
// Window ratio shifts (8, 16, 64)
// ----------------------------------------
`define SHIFT_RATIO_8 3'h3
`define SHIFT_RATIO_16 3'h4
`define SHIFT_RATIO_64 3'h6

`endif

// *** logic/supervisor_pkg.sv ***
package supervisor_pkg;

   typedef enum logic [2:0]
   {
      ST_HOLD = 3'b001,
      ST_STRETCH = 3'b010,
      ST_RUN = 3'b100
   } rst_state_t;

   typedef logic [31:0] word_t;
   typedef logic [11:0] apb_addr_t;

endpackage

// *** verif/sup_props.sv ***
`timescale 1ns/1ps
module sup_props
#(
   parameter int unsigned RST_FIXED_CYC = 20,
   parameter int unsigned WD_FIXED_CYC = 200
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Inputs
   input wire logic power_fail_sense,
   input wire logic supply_low,
   input wire logic reset_period_select,
   input wire logic wdog_period_select,
   input wire logic wdog_kick_in,
   input wire logic window_sel_lo,
   input wire logic window_sel_hi,
   input wire logic regulator_one_on,
   input wire logic keep_on_n,
   input wire logic keep_on_driven,
   // Outputs
   input wire logic supply_one_out,
   input wire logic reset_out_n,
   input wire logic power_fail_flag_n
);
   localparam int RLM = RST_FIXED_CYC - 1;
   logic [9:0] st_r;
   logic [9:0] idle_r;
   logic kick_r;
   logic off_w;
   assign off_w = window_sel_lo && !window_sel_hi;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // ------
   // Quiet time since the last supply-low or system reset and since the last kick
   // ------
   always_ff @(posedge clk_sys)
   begin
      st_r <= (sys_rst || supply_low) ? 10'h000 : st_r + {9'h000, ~&st_r};
   end
   always_ff @(posedge clk_sys)
   begin
      kick_r <= wdog_kick_in;
   end
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !reset_out_n || off_w || wdog_kick_in != kick_r)
         idle_r <= 10'h000;
      else
         idle_r <= idle_r + {9'h000, ~&idle_r};
   end
   property p_pf;
      power_fail_sense |=> !power_fail_flag_n;
   endproperty
   a_pf: assert property (p_pf) else $error("flag stays high");
   property p_low;
      supply_low |=> !reset_out_n;
   endproperty
   a_low: assert property (p_low) else $error("reset not held");
   property p_hold;
      reset_period_select && st_r < RST_FIXED_CYC - 2 |-> !reset_out_n;
   endproperty
   a_hold: assert property (p_hold) else $error("stretch too short");
   property p_late;
      wdog_period_select && !off_w |-> idle_r < WD_FIXED_CYC + 8;
   endproperty
   a_late: assert property (p_late) else $error("starved kick missed");
   property p_len;
      $fell(reset_out_n) && st_r > 10'h040 && reset_period_select
         |-> (!reset_out_n)[*8] and ##[RLM:RLM] (!reset_out_n ##1 reset_out_n);
   endproperty
   a_len: assert property (p_len) else $error("fault length wrong");
   property p_off;
      off_w && reset_out_n && !supply_low |=> reset_out_n;
   endproperty
   a_off: assert property (p_off) else $error("disabled dog fired");
   property p_keep;
      supply_one_out && keep_on_driven && !keep_on_n |=> supply_one_out;
   endproperty
   a_keep: assert property (p_keep) else $error("hold lost");
   property p_drop;
      !regulator_one_on && (keep_on_n || !keep_on_driven) |=> !supply_one_out;
   endproperty
   a_drop: assert property (p_drop) else $error("output stuck");
   c_fault: cover property ($fell(reset_out_n) && st_r > 10'h040);
   c_hold: cover property (supply_one_out && !regulator_one_on);
   c_pf: cover property ($fell(power_fail_flag_n));
endmodule

bind supervisor_watchdog_reset_hold sup_props
#(.RST_FIXED_CYC(RST_FIXED_CYC), .WD_FIXED_CYC(WD_FIXED_CYC)) sup_props_inst
(.clk_sys, .sys_rst, .power_fail_sense, .supply_low, .reset_period_select,
 .wdog_period_select, .wdog_kick_in, .window_sel_lo, .window_sel_hi, .regulator_one_on,
 .keep_on_n, .keep_on_driven, .supply_one_out, .reset_out_n, .power_fail_flag_n);

// *** verif/kick_cpu.sv ***
`timescale 1ns/1ps
module kick_cpu
(
   // Clock and reset seen by the processor
   input wire logic clk_sys,
   input wire logic reset_out_n,
   // Bench control
   input wire logic run,
   input wire logic [7:0] gap,
   // Kick line
   output logic wdog_kick_in
);
   logic [7:0] wait_r = 8'h00;
   initial wdog_kick_in = 1'b0;
   // Held in reset the wait restarts, so a slow gap never kicks early
   always @(posedge clk_sys)
   begin
      if (!reset_out_n || !run)
         wait_r <= 8'h00;
      else if (wait_r + 8'h01 >= gap)
      begin
         wait_r <= 8'h00;
         wdog_kick_in <= ~wdog_kick_in;
      end
      else
         wait_r <= wait_r + 8'h01;
   end
endmodule

// *** verif/tb_supervisor_watchdog_reset_hold.sv ***
`timescale 1ns/1ps
`include "supervisor_consts.svh"
module tb_supervisor_watchdog_reset_hold;
   import supervisor_pkg::*;
   localparam int RL = 20;
   logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   apb_addr_t paddr = 12'h000;
   word_t pwdata = 32'h0, prdata;
   logic pready, pslverr, supply_one_out, reset_out_n, power_fail_flag_n, irq, wdog_kick_in;
   logic power_fail_sense = 1'b0, supply_low = 1'b0, reset_period_select = 1'b1;
   logic wdog_period_select = 1'b1, window_sel_lo = 1'b0, window_sel_hi = 1'b0;
   logic regulator_one_on = 1'b0, keep_on_n = 1'b1, keep_on_driven = 1'b1, run = 1'b1;
   logic [7:0] gap = 8'h64;
   logic [33:0] note_q[$];
   logic [33:0] nt;
   int n_mismatch = 0, samples_checked = 0, n, i, v;
   always #12.5 clk_sys = ~clk_sys;
   supervisor_watchdog_reset_hold #(.RST_FIXED_CYC(RL), .WD_FIXED_CYC(200), .WINDOWED(1'b1))
   supervisor_watchdog_reset_hold_inst
   (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .power_fail_sense, .supply_low, .reset_period_select, .wdog_period_select, .wdog_kick_in,
    .window_sel_lo, .window_sel_hi, .wdog_off_n(1'b1), .regulator_one_on, .keep_on_n,
    .keep_on_driven, .supply_one_out, .reset_out_n, .power_fail_flag_n, .irq);
   kick_cpu kick_cpu_inst (.clk_sys, .reset_out_n, .run, .gap, .wdog_kick_in);
   // ------
   // Checking and bus tasks
   // ------
   task report_and_stop;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x)
      begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, x, s);
      end
   endtask
   task automatic apb(input logic wr, input apb_addr_t a, input word_t d, input logic [32:0] e);
      int k;
      @(posedge clk_sys);
      note_q.push_back({~wr, e});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk_sys);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20)
      begin
         n_mismatch++;
         report_and_stop();
      end
   endtask
   task automatic wait_rst(input logic lv, input int lim);
      n = 0;
      while (reset_out_n !== lv && n < lim)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= lim)
      begin
         n_mismatch++;
         report_and_stop();
      end
   endtask
   task automatic run_cnt(input int c);
      n = 0;
      repeat (c)
      begin
         @(posedge clk_sys);
         n += (reset_out_n !== 1'b1);
      end
   endtask
   always @(posedge clk_sys)
   begin
      if (pready === 1'b1 && note_q.size() > 0)
      begin
         nt = note_q.pop_front();
         chk("pslverr", 32'(pslverr), 32'(nt[32]));
         if (nt[33])
            chk("prdata", prdata, nt[31:0]);
      end
   end
   // ------
   // Scenarios
   // ------
   initial
   begin
      v = $urandom(32'h57CE4CB6);
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      wait_rst(1'b1, 60);
      chk("stretch", 32'(n >= RL && n <= RL + 3), 32'h1);
      apb(1'b0, `OFS_RST_ADJ, 32'h0, {1'b0, `RST_ADJ_RST});
      apb(1'b0, `OFS_WD_ADJ, 32'h0, {1'b0, `WD_ADJ_RST});
      apb(1'b0, `OFS_INT_EN, 32'h0, 33'h0);
      apb(1'b0, 12'h018, 32'h0, {1'b1, 32'h0});
      apb(1'b1, `OFS_STATUS, 32'hFFFFFFFF, 33'h0);
      apb(1'b0, `OFS_STATUS, 32'h0, 33'h00000000B);
      apb(1'b1, `OFS_INT_EN, 32'h1, 33'h0);
      apb(1'b0, `OFS_INT_EN, 32'h0, 33'h1);
      for (i = 0; i < 6; i++)
      begin
         gap <= 8'h1E + 8'($urandom % 32'h96);
         run_cnt(100);
         chk("kick_ok", 32'(n), 32'h0);
      end
      gap <= 8'h64;
      run <= 1'b0;
      wait_rst(1'b0, 300);
      wait_rst(1'b1, 60);
      chk("fault_len", 32'(n), RL);
      chk("irq_set", 32'(irq), 32'h1);
      run <= 1'b1;
      apb(1'b0, `OFS_INT_STAT, 32'h0, 33'h1);
      apb(1'b1, `OFS_INT_CLR, 32'h1, 33'h0);
      apb(1'b0, `OFS_INT_STAT, 32'h0, 33'h0);
      chk("irq_clr", 32'(irq), 32'h0);
      for (i = 0; i < 3; i++)
      begin
         {window_sel_hi, window_sel_lo} <= (i == 0) ? 2'b00 : (i == 1) ? 2'b10 : 2'b11;
         gap <= 8'h01;
         wait_rst(1'b0, 60);
         gap <= 8'h64;
         wait_rst(1'b1, 60);
      end
      {window_sel_hi, window_sel_lo} <= 2'b01;
      run <= 1'b0;
      run_cnt(400);
      chk("wd_off", 32'(n), 32'h0);
      run <= 1'b1;
      {window_sel_hi, window_sel_lo} <= 2'b00;
      for (i = 0; i < 2; i++)
      begin
         if (i == 1)
            apb(1'b1, `OFS_RST_ADJ, 32'h28, 33'h0);
         reset_period_select <= (i == 0);
         supply_low <= 1'b1;
         repeat (5) @(posedge clk_sys);
         chk("low_hold", 32'(reset_out_n), 32'h0);
         supply_low <= 1'b0;
         wait_rst(1'b1, 100);
         v = i ? 40 : RL;
         chk("stretch_len", 32'(n >= v && n <= v + 3), 32'h1);
      end
      reset_period_select <= 1'b1;
      wdog_period_select <= 1'b0;
      apb(1'b1, `OFS_WD_ADJ, 32'h12C, 33'h0);
      gap <= 8'hFA;
      run_cnt(800);
      chk("wd_adj", 32'(n), 32'h0);
      gap <= 8'h64;
      run_cnt(300);
      wdog_period_select <= 1'b1;
      repeat (20)
      begin
         v = $urandom % 2;
         power_fail_sense <= v[0];
         repeat (2) @(posedge clk_sys);
         chk("pf_flag", 32'(power_fail_flag_n), 32'(!v[0]));
      end
      regulator_one_on <= 1'b1;
      repeat (2) @(posedge clk_sys);
      keep_on_n <= 1'b0;
      @(posedge clk_sys);
      regulator_one_on <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("hold", 32'(supply_one_out), 32'h1);
      keep_on_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk("drop", 32'(supply_one_out), 32'h0);
      keep_on_driven <= 1'b0;
      keep_on_n <= 1'b0;
      regulator_one_on <= 1'b1;
      repeat (2) @(posedge clk_sys);
      regulator_one_on <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk("float", 32'(supply_one_out), 32'h0);
      repeat (4) @(posedge clk_sys);
      report_and_stop();
   end
endmodule
